// [design/fcsec_ctrl.sv]
// How it works
// - reset_powerdown_n stays high whenever any operation is suspended.
// - erase is setup 20h then confirm D0h carrying the block address.
// - after program or erase, controller clears status then returns to read array.
// - chip select idles high during pause; resume is written with chip select low.
// - identifier reads drive only the lowest address bit, others zero.
// - error bits are captured from every polling and read-status read, ready or not.
`timescale 1ns/1ps
`default_nettype none
module fcsec_ctrl
  import fcsec_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DQ_W = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // flash pins
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic reset_powerdown_n_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [DQ_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DQ_W-1:0] flash_dq_i
);
  // ****************************************
  // state
  // ****************************************
  fcsec_state_type st_ff;
  fcsec_op_type op_ff;
  logic [2:0] step_ff;
  logic [3:0] cnt_ff;
  logic rd_ff;
  logic [1:0] ctrl_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DQ_W-1:0] wdata_ff;
  logic [DQ_W-1:0] rdata_ff;
  logic [7:0] sr_ff;
  logic refused_ff;
  logic psusp_ff;
  logic esusp_ff;
  logic susp_req_ff;
  logic [ADDR_W-1:0] pin_addr_ff;
  logic [DQ_W-1:0] pin_dq_ff;
  logic [DQ_W-1:0] dq_sync;

  fcsec_sync2 #(.W(DQ_W)) u_dq_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .d_i(flash_dq_i),
    .q_o(dq_sync)
  );

  // ****************************************
  // apb decode
  // ****************************************
  wire apb_wr = psel_i && penable_i && pwrite_i;
  wire hit_ctrl = paddr_i == OFS_CTRL;
  wire hit_addr = paddr_i == OFS_ADDR;
  wire hit_wdata = paddr_i == OFS_WDATA;
  wire hit_cmd = paddr_i == OFS_CMD;
  wire hit_stat = paddr_i == OFS_STAT;
  wire hit_rdata = paddr_i == OFS_RDATA;
  wire mapped = hit_ctrl | hit_addr | hit_wdata | hit_cmd | hit_stat | hit_rdata;
  wire cmd_wr = apb_wr && hit_cmd;
  wire fcsec_op_type new_op = fcsec_op_type'(pwdata_i[2:0]);
  wire busy = st_ff != ST_IDLE;
  wire any_susp = psusp_ff | esusp_ff;

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o = hit_ctrl ? {30'h0, ctrl_ff} :
                    hit_addr ? 32'(addr_ff) :
                    hit_wdata ? 32'(wdata_ff) :
                    hit_stat ? {16'h0, sr_ff, 4'h0, esusp_ff, psusp_ff, refused_ff, busy} :
                    hit_rdata ? 32'(rdata_ff) : 32'h0;

  // ****************************************
  // command admission
  // ****************************************
  function automatic logic op_allowed(input fcsec_op_type op, input logic ps, input logic es);
    logic ok;
    ok = 1'b0;
    if (ps) begin
      ok = op inside {OP_READ_ARRAY, OP_READ_STATUS, OP_READ_ID, OP_RESUME};
    end else if (es) begin
      ok = op inside {OP_READ_ARRAY, OP_READ_STATUS, OP_READ_ID, OP_RESUME,
                      OP_PROGRAM};
    end else begin
      ok = !(op inside {OP_SUSPEND, OP_RESUME});
    end
    return ok;
  endfunction

  wire long_op = op_ff inside {OP_PROGRAM, OP_ERASE, OP_RESUME};
  wire polling = busy && long_op && step_ff == STEP_POLL;
  wire start = cmd_wr && !busy && op_allowed(new_op, psusp_ff, esusp_ff);
  wire susp_ask = cmd_wr && new_op == OP_SUSPEND && polling && !susp_req_ff;
  wire refuse = cmd_wr && !start && !susp_ask;

  // ****************************************
  // step table
  // ****************************************
  wire step_rd = (step_ff == 3'h1 && op_ff inside {OP_READ_ARRAY, OP_READ_ID, OP_READ_STATUS})
                 || step_ff == STEP_POLL;
  logic [7:0] first_code;
  always_comb begin
    unique case (op_ff)
      OP_READ_ARRAY: first_code = DC_READ_ARRAY;
      OP_READ_ID: first_code = DC_READ_ID;
      OP_READ_STATUS: first_code = DC_READ_STATUS;
      OP_CLEAR: first_code = DC_CLEAR_STATUS;
      OP_PROGRAM: first_code = ctrl_ff[CTRL_ALT_BIT] ? DC_PROG_SETUP_ALT
                                                     : DC_PROG_SETUP;
      OP_ERASE: first_code = DC_ERASE_SETUP;
      OP_SUSPEND: first_code = DC_SUSPEND;
      OP_RESUME: first_code = DC_CONFIRM;
    endcase
  end
  wire [DQ_W-1:0] step_data = step_ff == 3'h0 ? DQ_W'(first_code) :
                              step_ff == STEP_CLEAR ? DQ_W'(DC_CLEAR_STATUS) :
                              step_ff == STEP_ARRAY ? DQ_W'(DC_READ_ARRAY) :
                              op_ff == OP_ERASE ? DQ_W'(DC_CONFIRM) : wdata_ff;
  wire [ADDR_W-1:0] step_addr = step_ff != 3'h1 ? '0 :
                                op_ff == OP_READ_ID ? ADDR_W'(addr_ff[0]) : addr_ff;
  wire [3:0] strobe_last = rd_ff ? 4'(RD_CYC - 1) : 4'(WR_CYC - 1);
  wire sr_ready = rdata_ff[SR_READY];
  wire seq_end = (step_ff == 3'h0 && op_ff == OP_CLEAR)
                 || (step_ff == 3'h1 && !(op_ff inside {OP_PROGRAM, OP_ERASE}))
                 || (step_ff == STEP_POLL && op_ff == OP_SUSPEND && sr_ready)
                 || step_ff == STEP_ARRAY;
  wire [2:0] nxt_step = (step_ff == 3'h0 && op_ff inside {OP_SUSPEND, OP_RESUME}) ? STEP_POLL :
                        (step_ff == STEP_POLL && !sr_ready) ? STEP_POLL :
                        3'(step_ff + 3'h1);
  wire to_suspend = step_ff == STEP_POLL && long_op && !sr_ready && susp_req_ff;

  // ****************************************
  // pin sequencer
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= ST_IDLE;
      op_ff <= OP_READ_ARRAY;
      step_ff <= 3'h0;
      cnt_ff <= 4'h0;
      rd_ff <= 1'b0;
      pin_addr_ff <= '0;
      pin_dq_ff <= '0;
      rdata_ff <= '0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          if (start) begin
            op_ff <= new_op;
            step_ff <= 3'h0;
            st_ff <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          pin_addr_ff <= step_addr;
          pin_dq_ff <= step_data;
          rd_ff <= step_rd;
          st_ff <= ST_SETUP;
        end
        ST_SETUP: begin
          cnt_ff <= 4'h0;
          st_ff <= ST_STROBE;
        end
        ST_STROBE: begin
          cnt_ff <= 4'(cnt_ff + 4'h1);
          if (cnt_ff == strobe_last) begin
            st_ff <= ST_HOLD;
            if (rd_ff) begin
              rdata_ff <= dq_sync;
            end
          end
        end
        ST_HOLD: begin
          if (to_suspend) begin
            op_ff <= OP_SUSPEND;
            step_ff <= 3'h0;
            st_ff <= ST_LOAD;
          end else if (seq_end) begin
            st_ff <= ST_IDLE;
          end else begin
            step_ff <= nxt_step;
            st_ff <= ST_LOAD;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // software state and suspension tracking
  // ****************************************
  wire sr_capture = st_ff == ST_HOLD && rd_ff && (step_ff == STEP_POLL || op_ff == OP_READ_STATUS);
  wire susp_done = st_ff == ST_HOLD && op_ff == OP_SUSPEND && step_ff == STEP_POLL && sr_ready;
  wire resume_go = st_ff == ST_HOLD && op_ff == OP_RESUME && step_ff == 3'h0;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_ff <= CTRL_RESET;
      addr_ff <= '0;
      wdata_ff <= '0;
      sr_ff <= 8'h0;
      refused_ff <= 1'b0;
      psusp_ff <= 1'b0;
      esusp_ff <= 1'b0;
      susp_req_ff <= 1'b0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl_ff <= pwdata_i[1:0];
      end
      if (apb_wr && hit_addr && !busy) begin
        addr_ff <= pwdata_i[ADDR_W-1:0];
      end
      if (apb_wr && hit_wdata && !busy) begin
        wdata_ff <= pwdata_i[DQ_W-1:0];
      end
      if (sr_capture) begin
        sr_ff <= rdata_ff[7:0];
      end
      if (refuse) begin
        refused_ff <= 1'b1;
      end else if (apb_wr && hit_stat && pwdata_i[STAT_REFUSED_BIT]) begin
        refused_ff <= 1'b0;
      end
      if (susp_ask) begin
        susp_req_ff <= 1'b1;
      end else if (st_ff == ST_IDLE || op_ff == OP_SUSPEND) begin
        susp_req_ff <= 1'b0;
      end
      if (susp_done) begin
        psusp_ff <= psusp_ff | rdata_ff[SR_PROG_PAUSED];
        esusp_ff <= esusp_ff | rdata_ff[SR_ERASE_PAUSED];
      end else if (resume_go) begin
        if (psusp_ff) begin
          psusp_ff <= 1'b0;
        end else begin
          esusp_ff <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  wire cycle_on = st_ff inside {ST_SETUP, ST_STROBE, ST_HOLD};
  assign flash_ce_n_o = !cycle_on;
  assign flash_we_n_o = !(st_ff == ST_STROBE && !rd_ff);
  assign flash_oe_n_o = !(st_ff == ST_STROBE && rd_ff);
  assign flash_dq_oe_o = cycle_on && !rd_ff;
  assign flash_addr_o = pin_addr_ff;
  assign flash_dq_o = pin_dq_ff;
  assign reset_powerdown_n_o = ctrl_ff[CTRL_RP_BIT] | any_susp;

  // ****************************************
  // assertions
  // ****************************************
  property p_rp_held;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (psusp_ff || esusp_ff) |-> reset_powerdown_n_o;
  endproperty
  a_rp_held: assert property (p_rp_held) else $error("reset driven low while suspended");

  property p_erase_confirm;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff == ST_STROBE && op_ff == OP_ERASE && step_ff == 3'h1)
      |-> (flash_dq_o[7:0] == DC_CONFIRM && flash_addr_o == addr_ff && !flash_we_n_o);
  endproperty
  a_erase_confirm: assert property (p_erase_confirm) else $error("bad erase confirm");

  sequence s_write_strobe;
    !flash_we_n_o [*7] ##1 flash_we_n_o;
  endsequence
  property p_we_width;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $fell(flash_we_n_o) |-> s_write_strobe;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

  property p_fresh_poll;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $fell(flash_oe_n_o) |-> $past(flash_ce_n_o, 2);
  endproperty
  a_fresh_poll: assert property (p_fresh_poll) else $error("chip select not toggled");

  property p_ready_first;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      ($rose(psusp_ff) || $rose(esusp_ff)) |-> sr_ff[SR_READY];
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("pause taken before ready");

  property p_id_addr;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!flash_oe_n_o && op_ff == OP_READ_ID) |-> flash_addr_o[ADDR_W-1:1] == '0;
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("identifier address not zero");

  property p_cleanup;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff == ST_HOLD && step_ff == STEP_POLL && sr_ready && long_op && !susp_req_ff)
      |-> ##3 (st_ff == ST_STROBE && flash_dq_o[7:0] == DC_CLEAR_STATUS);
  endproperty
  a_cleanup: assert property (p_cleanup) else $error("no clear status after operation");

  property p_idle_ce;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff == ST_IDLE) |-> (flash_ce_n_o && flash_we_n_o && flash_oe_n_o && !flash_dq_oe_o);
  endproperty
  a_idle_ce: assert property (p_idle_ce) else $error("pins active while idle");

  property p_pause_cmds;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (psusp_ff && st_ff == ST_IDLE && start) |-> ##1 (op_ff != OP_PROGRAM && op_ff != OP_ERASE);
  endproperty
  a_pause_cmds: assert property (p_pause_cmds) else $error("illegal command while paused");
endmodule // fcsec_ctrl
`default_nettype wire

// [design/fcsec_pkg.sv]
`default_nettype none
package fcsec_pkg;
  // ****************************************
  // clock and pin timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int T_WR_STROBE_NS = 70;
  localparam int T_RD_STROBE_NS = 100;
  localparam int WR_CYC = (T_WR_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_RD_STROBE_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************
  // register offsets and fields
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam int CTRL_RP_BIT = 0;
  localparam int CTRL_ALT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int STAT_PSUSP_BIT = 2;
  localparam int STAT_ESUSP_BIT = 3;
  localparam int STAT_SR_LSB = 8;
  // ****************************************
  // operation_status layout
  // ****************************************
  localparam int SR_READY = 7;
  localparam int SR_ERASE_PAUSED = 6;
  localparam int SR_PROG_PAUSED = 2;
  // ****************************************
  // device command codes
  // ****************************************
  localparam logic [7:0] DC_READ_ARRAY = 8'hff;
  localparam logic [7:0] DC_READ_ID = 8'h90;
  localparam logic [7:0] DC_READ_STATUS = 8'h70;
  localparam logic [7:0] DC_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] DC_PROG_SETUP = 8'h40;
  localparam logic [7:0] DC_PROG_SETUP_ALT = 8'h10;
  localparam logic [7:0] DC_ERASE_SETUP = 8'h20;
  localparam logic [7:0] DC_CONFIRM = 8'hd0;
  localparam logic [7:0] DC_SUSPEND = 8'hb0;
  // ****************************************
  // software operation codes
  // ****************************************
  typedef enum logic [2:0] {
    OP_READ_ARRAY = 3'b000,
    OP_READ_ID = 3'b001,
    OP_READ_STATUS = 3'b010,
    OP_CLEAR = 3'b011,
    OP_PROGRAM = 3'b100,
    OP_ERASE = 3'b101,
    OP_SUSPEND = 3'b110,
    OP_RESUME = 3'b111
  } fcsec_op_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b100
  } fcsec_state_type;
  localparam logic [2:0] STEP_POLL = 3'h2;
  localparam logic [2:0] STEP_CLEAR = 3'h3;
  localparam logic [2:0] STEP_ARRAY = 3'h4;
endpackage
`default_nettype wire

// [design/fcsec_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module fcsec_sync2 #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // ****************************************
  // two-stage synchroniser
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule // fcsec_sync2
`default_nettype wire

// [verif/fcsec_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fcsec_flash_model #(
  parameter int PROG_CYC = 400,
  parameter int ERASE_CYC = 600,
  parameter logic [15:0] MFR_CODE = 16'h00a5,
  parameter logic [15:0] DEV_CODE = 16'h005a
) (
  // pins
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rp_n_i,
  input wire logic [21:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  // fault injection
  input wire logic vpp_ok_i,
  input wire logic erase_bad_i
);
  // ****************
  // state
  // ****************
  logic [6:0] sr;
  logic [15:0] mem [0:63];
  logic [1:0] mode, setup, eblk;
  logic we_q, oe_q;
  logic [5:0] pidx;
  logic [15:0] pval;
  logic [7:0] c;
  int pcnt, ecnt, lat;
  wire logic run_p = pcnt > 0 && !sr[2];
  wire logic run_e = ecnt > 0 && !sr[6] && pcnt == 0;
  wire logic [7:0] status = {~(run_p | run_e), sr};
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'hffff;
    sr = 0; mode = 0; setup = 0; pcnt = 0; ecnt = 0; lat = 0;
    we_q = 1; oe_q = 1; dq_o = 0; eblk = 0; pidx = 0; pval = 0;
  end
  // ****************
  // command decoder and machine
  // ****************
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    oe_q <= oe_n_i;
    c = dq_i[7:0];
    if (!rp_n_i) begin
      sr <= 0; mode <= 0; setup <= 0; pcnt <= 0; ecnt <= 0; lat <= 0;
    end else begin
      if (run_p) pcnt <= pcnt - 1;
      if (run_e) ecnt <= ecnt - 1;
      if (run_p && pcnt == 1) mem[pidx] <= mem[pidx] & pval;
      if (run_e && ecnt == 1) begin
        if (erase_bad_i) sr[5] <= 1'b1;
        else for (int i = 0; i < 16; i++) mem[{eblk, i[3:0]}] <= 16'hffff;
      end
      if (lat == 1 && run_p) sr[2] <= 1'b1;
      else if (lat == 1 && run_e) sr[6] <= 1'b1;
      if (lat > 0) lat <= lat - 1;
      if (we_n_i && !we_q && !ce_n_i) begin
        mode <= 2'd2;
        setup <= 0;
        if (setup == 1 && addr_i[21]) begin
          sr[1] <= 1'b1;
        end else if (setup == 1) begin
          pidx <= addr_i[5:0]; pval <= dq_i; pcnt <= PROG_CYC;
        end else if (setup == 2) begin
          if (c != 8'hd0) sr[5:4] <= 2'b11;
          else if (!vpp_ok_i) sr[5:3] <= 3'b101;
          else begin eblk <= addr_i[5:4]; ecnt <= ERASE_CYC; end
        end else if ((sr[2] | sr[6]) && !(c inside {8'hff, 8'h70, 8'h90, 8'hd0, 8'h50})
                     && !(sr[6] && !sr[2] && c inside {8'h40, 8'h10})
                     && !(run_p && c == 8'hb0)) begin
          sr[5:4] <= 2'b11;
        end else case (c)
          8'hff: mode <= 2'd0;
          8'h90: mode <= 2'd1;
          8'h50: {sr[5:3], sr[1]} <= 4'h0;
          8'h40, 8'h10: setup <= 2'd1;
          8'h20: setup <= 2'd2;
          8'hb0: if (run_p | run_e) lat <= 4;
          8'hd0: if (sr[2]) sr[2] <= 1'b0; else sr[6] <= 1'b0;
          default: ;
        endcase
      end
    end
    if (!ce_n_i && !oe_n_i && oe_q) begin
      case (mode)
        2'd0: dq_o <= mem[addr_i[5:0]];
        2'd1: dq_o <= addr_i[21:1] != 0 ? 16'hdead : addr_i[0] ? DEV_CODE : MFR_CODE;
        default: dq_o <= {8'h00, status};
      endcase
    end else if (ce_n_i || oe_n_i) dq_o <= ~dq_o;
  end
endmodule // fcsec_flash_model
`default_nettype wire

// [verif/tb_flash_cmd_suspend_erase_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_cmd_suspend_erase_ctrl
  import fcsec_pkg::*;
;
  // ****************
  // signals
  // ****************
  localparam logic [15:0] MFR = 16'h00a5; // arbitrary
  localparam logic [15:0] DEV = 16'h005a; // arbitrary
  logic clk_sys_i, nrst_i, psel, penable, pwrite, vpp_ok, ers_bad, pready, pslverr;
  logic ce_n, oe_n, we_n, rp_n, dq_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, e, m;
  logic [31:0] q_exp [$];
  logic [31:0] q_msk [$];
  logic [21:0] faddr, a;
  logic [15:0] dq_out, dq_mod, d;
  int failures, check_count, cyc, seed;
  wire logic [15:0] dq_bus = dq_oe ? dq_out : dq_mod;
  fcsec_ctrl i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
    .reset_powerdown_n_o(rp_n), .flash_addr_o(faddr), .flash_dq_o(dq_out),
    .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_bus));
  fcsec_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_flash (.clk_i(clk_sys_i), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .rp_n_i(rp_n), .addr_i(faddr), .dq_i(dq_bus), .dq_o(dq_mod),
    .vpp_ok_i(vpp_ok), .erase_bad_i(ers_bad));
  // ****************
  // tasks
  // ****************
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt,
                     input logic [31:0] mk);
    @(posedge clk_sys_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= dt;
    if (!w) begin q_exp.push_back(dt); q_msk.push_back(mk); end
    @(posedge clk_sys_i);
    penable <= 1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    rd = prdata;
    chk("pslverr", {31'h0, ad > OFS_RDATA}, {31'h0, pslverr});
    psel <= 0; penable <= 0;
  endtask
  task automatic wait_idle();
    apb(0, OFS_STAT, 0, 0);
    while (rd[STAT_BUSY_BIT] !== 1'b0) apb(0, OFS_STAT, 0, 0);
  endtask
  task automatic start(input fcsec_op_type o, input logic [21:0] ad, input logic [15:0] dt);
    apb(1, OFS_ADDR, {10'h0, ad}, 0);
    apb(1, OFS_WDATA, {16'h0, dt}, 0);
    apb(1, OFS_CMD, {29'h0, o}, 0);
  endtask
  task automatic run(input fcsec_op_type o, input logic [21:0] ad, input logic [15:0] dt);
    start(o, ad, dt);
    wait_idle();
  endtask
  task automatic pause();
    @(posedge clk_sys_i);
    while (oe_n !== 1'b0) @(posedge clk_sys_i);
    apb(1, OFS_CMD, {29'h0, OP_SUSPEND}, 0);
    wait_idle();
  endtask
  // ****************
  // monitor and sequence
  // ****************
  always @(posedge clk_sys_i) begin
    cyc++;
    if (psel && penable && pready && !pwrite) begin
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      if (m != 0) chk($sformatf("reg %h", paddr), e & m, prdata & m);
    end
    if ((i_flash.sr[2] | i_flash.sr[6]) && rp_n !== 1'b1) begin
      chk("rp_n", 1, {31'h0, rp_n});
    end
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    nrst_i = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    vpp_ok = 1; ers_bad = 0; failures = 0; check_count = 0; cyc = 0; seed = 28686;
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    apb(0, OFS_CTRL, 32'h1, '1);
    apb(0, OFS_STAT, 32'h0, '1);
    apb(0, 8'h1c, 32'h0, '1);
    for (int i = 0; i < 2; i++) begin
      a = 22'($random(seed));
      a[0] = i[0];
      run(OP_READ_ID, a, 0);
      apb(0, OFS_RDATA, {16'h0, i ? DEV : MFR}, 32'hffff);
    end
    for (int i = 0; i < 2; i++) begin
      d = 16'($random(seed));
      apb(1, OFS_CTRL, {30'h0, i[0], 1'b1}, 0);
      run(OP_PROGRAM, 22'(i), d);
      apb(0, OFS_STAT, 32'h8000, 32'hffff);
      run(OP_READ_ARRAY, 22'(i), 0);
      apb(0, OFS_RDATA, {16'h0, d}, 32'hffff);
    end
    d = 16'($random(seed));
    start(OP_PROGRAM, 22'h2, d);
    pause();
    apb(0, OFS_STAT, 32'h8404, 32'hffff);
    apb(1, OFS_CMD, {29'h0, OP_ERASE}, 0);
    apb(0, OFS_STAT, 32'h8406, 32'hffff);
    apb(1, OFS_STAT, 32'h2, 0);
    run(OP_READ_ARRAY, 22'd48, 0);
    apb(0, OFS_RDATA, 32'hffff, 32'hffff);
    run(OP_RESUME, 0, 0);
    apb(0, OFS_STAT, 32'h8000, 32'hffff);
    run(OP_READ_ARRAY, 22'h2, 0);
    apb(0, OFS_RDATA, {16'h0, d}, 32'hffff);
    run(OP_PROGRAM, 22'd20, 16'h0);
    start(OP_ERASE, 22'd21, 0);
    pause();
    apb(0, OFS_STAT, 32'hc008, 32'hffff);
    chk("ce_n", 1, {31'h0, ce_n});
    apb(1, OFS_CTRL, 32'h0, 0);
    @(posedge clk_sys_i);
    chk("rp_n", 1, {31'h0, rp_n});
    apb(1, OFS_CTRL, 32'h1, 0);
    d = 16'($random(seed));
    start(OP_PROGRAM, 22'd40, d);
    pause();
    apb(0, OFS_STAT, 32'hc40c, 32'hffff);
    run(OP_READ_ARRAY, 22'd50, 0);
    apb(0, OFS_RDATA, 32'hffff, 32'hffff);
    run(OP_RESUME, 0, 0);
    apb(0, OFS_STAT, 32'hc008, 32'hffff);
    run(OP_RESUME, 0, 0);
    apb(0, OFS_STAT, 32'h8000, 32'hffff);
    for (int i = 0; i < 2; i++) begin
      run(OP_READ_ARRAY, i ? 22'd40 : 22'd20, 0);
      apb(0, OFS_RDATA, {16'h0, i ? d : 16'hffff}, 32'hffff);
    end
    vpp_ok <= 1'b0;
    run(OP_ERASE, 22'd56, 0);
    apb(0, OFS_STAT, 32'ha800, 32'hffff);
    vpp_ok <= 1'b1;
    ers_bad <= 1'b1;
    run(OP_ERASE, 22'd56, 0);
    apb(0, OFS_STAT, 32'ha000, 32'hffff);
    ers_bad <= 1'b0;
    run(OP_PROGRAM, 22'h200000, 16'h0);
    apb(0, OFS_STAT, 32'h8200, 32'hffff);
    run(OP_READ_STATUS, 0, 0);
    apb(0, OFS_RDATA, 32'h0080, 32'hffff);
    apb(1, OFS_CMD, {29'h0, OP_SUSPEND}, 0);
    apb(0, OFS_STAT, 32'h2, 32'hff);
    apb(1, OFS_STAT, 32'h2, 0);
    apb(0, OFS_STAT, 32'h0, 32'hff);
    end_sim();
  end
endmodule // tb_flash_cmd_suspend_erase_ctrl
`default_nettype wire
